// ==== hdl/match_timer.sv ====
// eight-bit match timer and event counter with register port and shared pin
// Behaviour
// RL1: run bit clear zeroes and stops counter
// RL2: bit six selects clear-on-match or pwm
// RL3: preset pair: none, force low, force high
// RL4: preset bits always read back zero
// RL5: preset ignored while pwm mode selected
// RL6: invert bit toggles or sets pwm polarity
// RL7: output low unless output enable set
// RL8: output settings act even while stopped
// RL9: software writes control fields in order
// RL10: stop counter before changing mode bit
// RL11: pwm stop drives output inactive level
// RL12: direction bits: zero drives, reset ones
// RL13: software sets direction and latch for pin
// RL14: match clears counter, keeps counting, interrupts
// RL15: interval is compare plus one ticks
// RL16: three-bit field selects count clock
// RL17: codes zero and one count pin edges
// RL18: match toggles flop in the same cycle the counter clears
// RL19: square wave period twice compare plus one
// RL20: compare unchanged while counting by software
// RL21: square wave uses stopped setup patterns
// RL22: reset clears mode control to zero
// RL23: stop timer before changing clock select
// RL24: match interrupt is one-cycle pulse; held high every cycle while compare is zero at the undivided clock in clear-on-match mode
`timescale 1ns/1ps
`include "match_timer_params.svh"

module match_timer #(
    parameter int COUNT_WIDTH = `DATA_WIDTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire match_timer_pkg::bus_req_type bus_req,
    output logic [7:0] rdata,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic [7:0] port1_direction,
    output logic match_interrupt
);

    match_timer_pkg::timer_state_type st_reg;
    match_timer_pkg::timer_state_type st_next;

    logic edge_rise;
    logic edge_fall;
    logic prescale_tick;
    logic [3:0] prescale_shift;
    logic count_tick;
    logic timer_output;
    logic wr_mode;
    logic [7:0] mode_written;
    logic [1:0] preset;

    // decode of an address hit for a strobe
    function automatic logic hit(input logic strobe, input logic [15:0] addr, input logic [15:0] target);
        hit = strobe && (addr == target);
    endfunction

    // divider shift for an internal clock code
    function automatic logic [3:0] shift_of(input logic [2:0] sel);
        logic [3:0] s;
        s = `SHIFT_DIV1;
        unique case (sel)
            `SEL_DIV2: s = `SHIFT_DIV2;
            `SEL_DIV16: s = `SHIFT_DIV16;
            `SEL_DIV64: s = `SHIFT_DIV64;
            `SEL_DIV256: s = `SHIFT_DIV256;
            `SEL_DIV4096: s = `SHIFT_DIV4096;
            default: s = `SHIFT_DIV1;
        endcase
        return s;
    endfunction

    pin_edge_detect u_edge (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(pin_in),
        .rise(edge_rise),
        .fall(edge_fall)
    );

    count_prescaler #(
        .WIDTH(`PRESCALE_WIDTH)
    ) u_prescaler (
        .clk(clk),
        .rst_n(rst_n),
        .shift(prescale_shift),
        .tick(prescale_tick)
    );

    // count clock source
    always_comb begin
        prescale_shift = shift_of(st_reg.count_clock_select); // RL16
        unique case (st_reg.count_clock_select)
            `SEL_FALLING: count_tick = edge_fall; // RL17
            `SEL_RISING: count_tick = edge_rise; // RL17
            default: count_tick = prescale_tick; // RL16
        endcase
    end

    assign wr_mode = hit(bus_req.wr, bus_req.addr, `ADDR_MODE_CONTROL);
    assign mode_written = bus_req.wdata & `MODE_READ_MASK;
    assign preset = {bus_req.wdata[`BIT_PRESET_HIGH], bus_req.wdata[`BIT_PRESET_LOW]};

    // next-state logic
    always_comb begin
        st_next = st_reg;
        st_next.match_pulse = 1'b0;
        st_next.rdata = 8'h00;

        // register writes
        if (hit(bus_req.wr, bus_req.addr, `ADDR_PORT1_DIRECTION)) begin
            st_next.port1_direction = bus_req.wdata; // RL12
        end
        if (hit(bus_req.wr, bus_req.addr, `ADDR_PORT3_DIRECTION)) begin
            st_next.port3_direction = bus_req.wdata; // RL12
        end
        if (hit(bus_req.wr, bus_req.addr, `ADDR_PORT3_LATCH)) begin
            st_next.port3_latch = bus_req.wdata;
        end
        if (hit(bus_req.wr, bus_req.addr, `ADDR_COMPARE_VALUE)) begin
            st_next.compare_value = bus_req.wdata;
        end
        if (hit(bus_req.wr, bus_req.addr, `ADDR_COUNT_CLOCK_SELECT)) begin
            st_next.count_clock_select = bus_req.wdata[`CLOCK_SELECT_WIDTH-1:0]; // RL16
        end
        if (wr_mode) begin
            st_next.mode_control = mode_written; // RL4
        end

        // counting engine
        unique case (st_reg.run_state)
            match_timer_pkg::STOPPED: begin
                st_next.count_register = `RESET_COUNT; // RL1
                st_next.pwm_active = 1'b0; // RL11
            end
            match_timer_pkg::CLEAR_ON_MATCH: begin
                if (count_tick) begin
                    if (st_reg.count_register == st_reg.compare_value) begin
                        st_next.count_register = `RESET_COUNT; // RL14
                        st_next.match_pulse = 1'b1; // RL24
                        if (st_reg.mode_control[`BIT_INVERT]) begin
                            st_next.flop = ~st_reg.flop; // RL6 RL18 RL19
                        end
                    end else begin
                        st_next.count_register = st_reg.count_register + 8'h01; // RL15
                    end
                end
            end
            match_timer_pkg::PWM_RUN: begin
                if (count_tick) begin
                    st_next.count_register = st_reg.count_register + 8'h01;
                    if (st_reg.count_register == `COUNT_MAX) begin
                        st_next.pwm_active = 1'b1;
                    end else if (st_reg.count_register == st_reg.compare_value) begin
                        st_next.pwm_active = 1'b0;
                        st_next.match_pulse = 1'b1;
                    end
                end
            end
        endcase

        // run state follows the written run and mode bits
        if (!st_next.mode_control[`BIT_COUNT_RUN]) begin
            st_next.run_state = match_timer_pkg::STOPPED; // RL1
        end else if (st_next.mode_control[`BIT_PWM_MODE]) begin
            st_next.run_state = match_timer_pkg::PWM_RUN; // RL2
        end else begin
            st_next.run_state = match_timer_pkg::CLEAR_ON_MATCH; // RL2
        end
        if (!st_reg.mode_control[`BIT_COUNT_RUN] && st_next.mode_control[`BIT_COUNT_RUN]) begin
            st_next.count_register = `RESET_COUNT; // RL1
        end
        if (wr_mode && !bus_req.wdata[`BIT_COUNT_RUN]) begin
            st_next.count_register = `RESET_COUNT; // RL1
            st_next.pwm_active = 1'b0; // RL11
        end

        // flop preset, ignored in pwm mode; a preset wins over a match toggle
        if (wr_mode && !bus_req.wdata[`BIT_PWM_MODE]) begin // RL5
            unique case (preset)
                `PRESET_FORCE_LOW: st_next.flop = 1'b0; // RL3
                `PRESET_FORCE_HIGH: st_next.flop = 1'b1; // RL3
                default: st_next.flop = st_next.flop; // RL3
            endcase
        end

        // read data, one cycle after the strobe
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `ADDR_PORT1_DIRECTION: st_next.rdata = st_reg.port1_direction;
                `ADDR_PORT3_DIRECTION: st_next.rdata = st_reg.port3_direction;
                `ADDR_PORT3_LATCH: st_next.rdata = st_reg.port3_latch;
                `ADDR_MODE_CONTROL: st_next.rdata = st_reg.mode_control & `MODE_READ_MASK; // RL4
                `ADDR_COMPARE_VALUE: st_next.rdata = st_reg.compare_value;
                `ADDR_COUNT_REGISTER: st_next.rdata = st_reg.count_register;
                `ADDR_COUNT_CLOCK_SELECT: st_next.rdata = {5'h00, st_reg.count_clock_select};
                default: st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg.port1_direction <= `RESET_DIRECTION; // RL12
            st_reg.port3_direction <= `RESET_DIRECTION; // RL12
            st_reg.port3_latch <= `RESET_LATCH;
            st_reg.mode_control <= `RESET_MODE_CONTROL; // RL22
            st_reg.compare_value <= `RESET_COMPARE;
            st_reg.count_clock_select <= `RESET_CLOCK_SELECT;
            st_reg.count_register <= `RESET_COUNT;
            st_reg.flop <= 1'b0;
            st_reg.pwm_active <= 1'b0;
            st_reg.match_pulse <= 1'b0;
            st_reg.rdata <= 8'h00;
            st_reg.run_state <= match_timer_pkg::STOPPED;
        end else begin
            st_reg <= st_next;
        end
    end

    // timer output, live from the control bits in any run state
    always_comb begin
        if (!st_reg.mode_control[`BIT_OUTPUT_ENABLE]) begin
            timer_output = 1'b0; // RL7 RL8
        end else if (st_reg.mode_control[`BIT_PWM_MODE]) begin
            timer_output = st_reg.pwm_active ^ st_reg.mode_control[`BIT_INVERT]; // RL6 RL11 RL8
        end else begin
            timer_output = st_reg.flop; // RL7 RL8
        end
    end

    // shared pin: latch or timer output, driven while direction bit is zero
    assign pin_out = st_reg.port3_latch[`PIN_BIT] | timer_output; // RL13
    assign pin_oe = ~st_reg.port3_direction[`PIN_BIT]; // RL12
    assign port1_direction = st_reg.port1_direction;
    assign match_interrupt = st_reg.match_pulse; // RL24
    assign rdata = st_reg.rdata;

endmodule // match_timer

// ==== hdl/match_timer_params.svh ====
// register map, field positions, reset values and clock codes of the match timer
`ifndef MATCH_TIMER_PARAMS_SVH
`define MATCH_TIMER_PARAMS_SVH

`define ADDR_WIDTH 16
`define DATA_WIDTH 8

`define ADDR_PORT1_DIRECTION 16'hff21
`define ADDR_PORT3_DIRECTION 16'hff23
`define ADDR_MODE_CONTROL 16'hff43
`define ADDR_COMPARE_VALUE 16'hff44
`define ADDR_COUNT_REGISTER 16'hff45
`define ADDR_COUNT_CLOCK_SELECT 16'hff46
`define ADDR_PORT3_LATCH 16'hff47

`define RESET_DIRECTION 8'hff
`define RESET_MODE_CONTROL 8'h00
`define RESET_COMPARE 8'h00
`define RESET_CLOCK_SELECT 3'h0
`define RESET_LATCH 8'h00
`define RESET_COUNT 8'h00
`define COUNT_MAX 8'hff

`define BIT_COUNT_RUN 7
`define BIT_PWM_MODE 6
`define BIT_PRESET_HIGH 3
`define BIT_PRESET_LOW 2
`define BIT_INVERT 1
`define BIT_OUTPUT_ENABLE 0
`define MODE_READ_MASK 8'hc3
`define PRESET_FORCE_LOW 2'h1
`define PRESET_FORCE_HIGH 2'h2

`define PIN_BIT 3
`define CLOCK_SELECT_WIDTH 3
`define SEL_FALLING 3'h0
`define SEL_RISING 3'h1
`define SEL_DIV1 3'h2
`define SEL_DIV2 3'h3
`define SEL_DIV16 3'h4
`define SEL_DIV64 3'h5
`define SEL_DIV256 3'h6
`define SEL_DIV4096 3'h7

`define PRESCALE_WIDTH 12
`define SHIFT_DIV1 4'h0
`define SHIFT_DIV2 4'h1
`define SHIFT_DIV16 4'h4
`define SHIFT_DIV64 4'h6
`define SHIFT_DIV256 4'h8
`define SHIFT_DIV4096 4'hc

`endif

// ==== hdl/match_timer_pkg.sv ====
// types shared by the match timer files
package match_timer_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    typedef enum logic [2:0] {
        STOPPED = 3'h1,
        CLEAR_ON_MATCH = 3'h2,
        PWM_RUN = 3'h4
    } run_state_type;

    typedef struct packed {
        logic [7:0] port1_direction;
        logic [7:0] port3_direction;
        logic [7:0] port3_latch;
        logic [7:0] mode_control;
        logic [7:0] compare_value;
        logic [2:0] count_clock_select;
        logic [7:0] count_register;
        logic flop;
        logic pwm_active;
        logic match_pulse;
        logic [7:0] rdata;
        run_state_type run_state;
    } timer_state_type;

    typedef struct packed {
        logic [1:0] sync;
        logic last;
        logic rise;
        logic fall;
    } edge_state_type;

endpackage

// ==== hdl/count_prescaler.sv ====
// free-running divider giving one-cycle count ticks for the internal clock codes
`timescale 1ns/1ps
`include "match_timer_params.svh"

module count_prescaler #(
    parameter int WIDTH = `PRESCALE_WIDTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] shift,
    output logic tick
);

    logic [WIDTH-1:0] div_reg;
    logic [WIDTH-1:0] div_next;
    logic [WIDTH-1:0] mask;

    always_comb begin
        div_next = div_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        mask = WIDTH'(({{(WIDTH){1'b0}}, 1'b1} << shift) - 1);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    // tick when the low shift bits are all ones
    assign tick = ((div_reg & mask) == mask);

endmodule // count_prescaler

// ==== hdl/pin_edge_detect.sv ====
// two-flop synchroniser and edge detector for the event input pin
`timescale 1ns/1ps

module pin_edge_detect (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic rise,
    output logic fall
);

    match_timer_pkg::edge_state_type st_reg;
    match_timer_pkg::edge_state_type st_next;

    always_comb begin
        st_next = st_reg;
        st_next.sync = {st_reg.sync[0], pin_in};
        st_next.last = st_reg.sync[1];
        st_next.rise = st_reg.sync[1] & ~st_reg.last;
        st_next.fall = ~st_reg.sync[1] & st_reg.last;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rise = st_reg.rise;
    assign fall = st_reg.fall;

endmodule // pin_edge_detect

// ==== bench/timer_checker.sv ====
// port assertions for the match timer
`timescale 1ns/1ps
module timer_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire match_timer_pkg::bus_req_type bus_req,
    input wire logic [7:0] rdata,
    input wire logic pin_in,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic [7:0] port1_direction,
    input wire logic match_interrupt
);
    logic run_reg, pwm_reg, oe_reg, latch_reg, dirty_reg;
    logic [7:0] cmp_reg;
    logic [2:0] sel_reg;
    logic [8:0] gap_reg;
    logic [15:0] a;
    logic w;
    assign a = bus_req.addr;
    assign w = bus_req.wr;
    // shadow of the written settings and cycles since the last match
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {run_reg, pwm_reg, oe_reg, latch_reg, dirty_reg} <= 5'h01;
            cmp_reg <= 8'h00;
            sel_reg <= 3'h0;
            gap_reg <= 9'h000;
        end else begin
            if (w && a == 16'hff43) {run_reg, pwm_reg, oe_reg} <= {bus_req.wdata[7:6], bus_req.wdata[0]};
            if (w && a == 16'hff47) latch_reg <= bus_req.wdata[3];
            if (w && a == 16'hff44) cmp_reg <= bus_req.wdata;
            if (w && a == 16'hff46) sel_reg <= bus_req.wdata[2:0];
            dirty_reg <= (w && a inside {16'hff43, 16'hff44, 16'hff46}) ? 1'b1 : (match_interrupt ? 1'b0 : dirty_reg);
            gap_reg <= match_interrupt ? 9'h001 : gap_reg + {8'h00, gap_reg != 9'h1ff};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_ctl_read;
        bus_req.rd && a == 16'hff43;
    endsequence
    a_rdata_idle: assert property (!bus_req.rd |=> rdata == 8'h00) else $error("read data not idle");
    a_preset_reads_zero: assert property (s_ctl_read |=> rdata[3:2] == 2'h0) else $error("preset read");
    a_dir_after_reset: assert property ($rose(rst_n) |-> port1_direction == 8'hff && !pin_oe)
        else $error("direction reset");
    a_dir_write: assert property (w && a == 16'hff21 |=> port1_direction == $past(bus_req.wdata))
        else $error("direction write");
    a_oe_from_dir: assert property (w && a == 16'hff23 |=> pin_oe == !$past(bus_req.wdata[3]))
        else $error("pin enable");
    a_out_disabled_low: assert property (!oe_reg && !$past(oe_reg) && !latch_reg && !$past(latch_reg) |-> !pin_out)
        else $error("output not low");
    a_stopped_no_irq: assert property (!run_reg && !$past(run_reg) && !$past(run_reg, 2) |-> !match_interrupt)
        else $error("match while stopped");
    a_stopped_count_zero: assert property (bus_req.rd && a == 16'hff45 && !run_reg && !$past(run_reg) |=> rdata == 8'h00)
        else $error("count not cleared");
    a_match_interval: assert property (match_interrupt && !dirty_reg && !pwm_reg && sel_reg == 3'h2 |-> gap_reg == cmp_reg + 9'h001)
        else $error("match interval");
    a_irq_single: assert property (match_interrupt && sel_reg != 3'h2 |=> !match_interrupt)
        else $error("match pulse long");
endmodule // timer_checker

// ==== bench/pin_partner.sv ====
// external device driving the event pin with bursts of level changes
`timescale 1ns/1ps
module pin_partner (
    input wire logic clk,
    input wire logic start,
    input wire logic [7:0] toggles,
    output logic pin_level,
    output logic busy
);
    logic [7:0] left;
    logic [1:0] phase;
    assign busy = left != 8'h00;
    initial begin
        pin_level = 1'b0;
        left = 8'h00;
        phase = 2'h0;
    end
    // changes spaced four cycles so the synchroniser sees every edge
    always @(posedge clk) begin
        phase <= phase + 2'h1;
        if (start) begin
            left <= toggles;
        end else if (busy && phase == 2'h3) begin
            pin_level <= ~pin_level;
            left <= left - 8'h01;
        end
    end
endmodule // pin_partner

// ==== bench/tb_top.sv ====
// self-checking bench for the match timer
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic clk, rst_n, pin_out, pin_oe, irq, go, busy, pin;
    match_timer_pkg::bus_req_type bus_req;
    logic [7:0] rdata, p1dir, rv, d, nt;
    int miscompares, n_checks, seed, cyc, gcnt, n, rises, exp_n;
    int gaps[$];
    logic lvls[$];
    int sels[5] = '{2, 3, 4, 2, 2};
    int divs[5] = '{1, 2, 16, 1, 1};
    match_timer DUT (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata), .pin_in(pin), .pin_out(pin_out),
        .pin_oe(pin_oe), .port1_direction(p1dir), .match_interrupt(irq));
    pin_partner far_end (.clk(clk), .start(go), .toggles(nt), .pin_level(pin), .busy(busy));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // match spacing, output level at each match, and the run ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            miscompares++;
            report_and_stop();
        end
        if (irq === 1'b1) begin
            gaps.push_back(gcnt);
            lvls.push_back(pin_out);
            gcnt = 1;
        end else begin
            gcnt++;
        end
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.wdata <= v;
        bus_req.wr <= 1'b1;
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 rv = rdata;
        `CHK(rv, e)
    endtask
    task automatic ctl(input logic [7:0] v, input logic e);
        wr(16'hff43, v);
        repeat (2) @(posedge clk);
        #1 `CHK(pin_out, e)
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        seed = 4987;
        rst_n = 1'b0;
        bus_req = '0;
        go = 1'b0;
        nt = 8'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rchk(16'hff21, 8'hff);
        rchk(16'hff23, 8'hff);
        rchk(16'hff43, 8'h00);
        rchk(16'hff50, 8'h00);
        d = 8'($random(seed));
        wr(16'hff21, d);
        rchk(16'hff21, d);
        `CHK(p1dir, d)
        $display("registers done");
        wr(16'hff47, 8'h00);
        wr(16'hff23, 8'h00);
        #1;
        `CHK(pin_oe, 1'b1)
        ctl(8'h0b, 1'b1);
        rchk(16'hff43, 8'h03);
        ctl(8'h07, 1'b0);
        ctl(8'h0f, 1'b0);
        ctl(8'h0b, 1'b1);
        ctl(8'h0a, 1'b0);
        ctl(8'h07, 1'b0);
        ctl(8'h4b, 1'b1);
        ctl(8'h03, 1'b0);
        $display("output control done");
        for (int i = 0; i < 5; i++) begin
            n = i < 3 ? ($random(seed) & 15) + 1 : (i == 3 ? 0 : 255);
            wr(16'hff44, n[7:0]);
            wr(16'hff46, sels[i][7:0]);
            wr(16'hff43, 8'h83);
            gaps.delete();
            lvls.delete();
            repeat (2000) if (gaps.size() < 3) @(posedge clk);
            exp_n = (n + 1) * divs[i];
            `CHK(gaps[2], exp_n)
            `CHK(lvls[2], !lvls[1])
            wr(16'hff43, 8'h03);
            rchk(16'hff45, 8'h00);
        end
        $display("interval done");
        for (int v = 0; v < 2; v++) begin
            wr(16'hff43, v ? 8'h43 : 8'h41);
            wr(16'hff43, v ? 8'hc3 : 8'hc1);
            repeat (300) @(posedge clk);
            ctl(v ? 8'h43 : 8'h41, v[0]);
        end
        $display("pwm stop done");
        wr(16'hff23, 8'h08);
        #1;
        `CHK(pin_oe, 1'b0)
        wr(16'hff44, 8'hff);
        for (int s = 0; s < 2; s++) begin
            wr(16'hff46, s[7:0]);
            wr(16'hff43, 8'h80);
            n = ($random(seed) & 15) + 1;
            rises = pin ? n / 2 : (n + 1) / 2;
            exp_n = s ? rises : n - rises;
            nt <= 8'(n);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            #1;
            repeat (200) if (busy) @(posedge clk);
            repeat (5) @(posedge clk);
            rchk(16'hff45, exp_n[7:0]);
            wr(16'hff43, 8'h00);
        end
        $display("event count done");
        report_and_stop();
    end
endmodule // tb_top
bind match_timer timer_checker chk (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .port1_direction(port1_direction), .match_interrupt(match_interrupt));
